/* verilog/drkc_consts.vh */
`ifndef DRKC_CONSTS_VH
`define DRKC_CONSTS_VH
// clock rate in kHz (200 MHz)
`define DRKC_CLK_KHZ 200000
// cts delays in ms
`define DRKC_CTS_SHORT_MS 10
`define DRKC_CTS_LONG_MS 20
// key hold times in ms
`define DRKC_HOLD_SHORT_MS 1
`define DRKC_HOLD_LONG_MS 20
// power-up delay before continuous keying, in ms
`define DRKC_PWRUP_MS 10
// derived cycle counts
`define DRKC_CTS_SHORT_CYC (`DRKC_CTS_SHORT_MS * `DRKC_CLK_KHZ)
`define DRKC_CTS_LONG_CYC (`DRKC_CTS_LONG_MS * `DRKC_CLK_KHZ)
`define DRKC_HOLD_SHORT_CYC (`DRKC_HOLD_SHORT_MS * `DRKC_CLK_KHZ)
`define DRKC_HOLD_LONG_CYC (`DRKC_HOLD_LONG_MS * `DRKC_CLK_KHZ)
`define DRKC_PWRUP_CYC (`DRKC_PWRUP_MS * `DRKC_CLK_KHZ)
// counter width
`define DRKC_CW 24
`define DRKC_ONE 24'h000001
`define DRKC_ZERO 24'h000000
`endif

/* verilog/drkc_delay.v */
`timescale 1ns/1ps
`include "drkc_consts.vh"
// ==========================================================
// on/off delay: output rises after trigger high for on_len
// cycles, falls after trigger low for off_len cycles
module drkc_delay #(
  parameter CW = `DRKC_CW
) (
  input wire clk_i,
  input wire rst_i,
  input wire trig_i,
  input wire [CW-1:0] on_len_i,
  input wire [CW-1:0] off_len_i,
  output reg out_o
);
  reg [CW-1:0] cnt;
  reg trig_d;

  // counter restarts on every change of trigger
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {CW{1'b0}};
      trig_d <= 1'b0;
      out_o <= 1'b0;
    end else begin
      trig_d <= trig_i;
      if (trig_i != trig_d) begin
        cnt <= {{(CW-1){1'b0}}, 1'b1};
      end else if (trig_i != out_o) begin
        if (cnt >= (trig_i ? on_len_i : off_len_i)) begin
          out_o <= trig_i;
        end else begin
          cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* verilog/drkc_top.v */
`timescale 1ns/1ps
`include "drkc_consts.vh"
// Summary of operation
// - cts delay 10 ms or 20 ms on, selected by switch
// - keying switch off gives continuous key
// - switched key on rts or receive signal
// - hold key 1 ms or 20 ms after drop
// - continuous key after short power-up delay
// - key enable off leaves key request undriven
// - key enable on keys on squelch open
// - tx data from rx, terminal data while rts
// - receive data also presented on rxd
// - carrier detect passed to dcd
// - synchronizer used only when enabled
// - sleep input low sleeps both radios
// - orderwire voice keys transmitter in analog
// - orderwire voice selects analog mode automatically
// - one transmit data source at a time
// - rts drop returns path to repeating
module drkc_top #(
  parameter CTS_SHORT_CYC = `DRKC_CTS_SHORT_CYC,
  parameter CTS_LONG_CYC = `DRKC_CTS_LONG_CYC,
  parameter HOLD_SHORT_CYC = `DRKC_HOLD_SHORT_CYC,
  parameter HOLD_LONG_CYC = `DRKC_HOLD_LONG_CYC,
  parameter PWRUP_CYC = `DRKC_PWRUP_CYC
) (
  // clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // board switch settings
  input wire CTS_DELAY_SELECT_I,
  input wire TRANSMIT_KEY_MODE_SELECT_I,
  input wire KEY_HOLD_SELECT_I,
  input wire TRANSMITTER_KEY_INPUT_ENABLE_I,
  input wire SYNCHRONIZER_ENABLE_I,
  // terminal port
  input wire TERM_RTS_I,
  input wire TERM_TXD_I,
  output reg TERM_CTS_O,
  output reg TERM_RXD_O,
  output reg TERM_DCD_O,
  input wire SLEEP_N_I,
  // receiver radio
  input wire RX_DATA_I,
  input wire RX_CARRIER_I,
  input wire RX_SQUELCH_OPEN_I,
  // plug-in synchronizer
  input wire SYNC_DATA_I,
  output reg SYNC_DATA_O,
  // orderwire handset
  input wire VOICE_ACTIVE_I,
  // transmitter radio and sleep
  output reg TX_DATA_O,
  output reg TRANSMITTER_KEY_REQUEST_O,
  output reg TRANSMITTER_KEY_REQUEST_OE_O,
  output reg TX_ANALOG_MODE_O,
  output reg RADIOS_SLEEP_O
);
  // lengths are cut to the counter width on purpose
  // the counter is wide enough for the longest delay
  localparam CW = `DRKC_CW;
  localparam [CW-1:0] CTS_S = CTS_SHORT_CYC;
  localparam [CW-1:0] CTS_L = CTS_LONG_CYC;
  localparam [CW-1:0] HOLD_S = HOLD_SHORT_CYC;
  localparam [CW-1:0] HOLD_L = HOLD_LONG_CYC;
  localparam [CW-1:0] PWRUP = PWRUP_CYC;

  wire cts_del;
  wire key_held;
  wire key_src;
  wire [CW-1:0] cts_len;
  wire [CW-1:0] hold_len;
  reg [CW-1:0] pwr_cnt;
  reg pwr_done;
  reg next_key;
  reg next_key_req;
  reg next_tx_data;

  // ========================================================
  // cts delay toward terminal port
  // gives the transmitter time to key before terminal data
  assign cts_len = CTS_DELAY_SELECT_I ? CTS_S : CTS_L;
  drkc_delay #(.CW(CW)) u_cts (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .trig_i(TERM_RTS_I),
    .on_len_i(cts_len),
    .off_len_i(`DRKC_ONE),
    .out_o(cts_del)
  );

  // ========================================================
  // switched keying with hold, restarted on reassertion
  // the hold bridges short gaps so the link does not drop
  assign key_src = TERM_RTS_I | RX_SQUELCH_OPEN_I | VOICE_ACTIVE_I;
  assign hold_len = KEY_HOLD_SELECT_I ? HOLD_S : HOLD_L;
  drkc_delay #(.CW(CW)) u_hold (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .trig_i(key_src),
    .on_len_i(`DRKC_ZERO),
    .off_len_i(hold_len),
    .out_o(key_held)
  );

  // ========================================================
  // power-up delay for continuous keying
  // counter stops once done, so it never wraps and rekeys
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_cnt <= `DRKC_ZERO;
      pwr_done <= 1'b0;
    end else if (!pwr_done) begin
      if (pwr_cnt >= PWRUP) begin
        pwr_done <= 1'b1;
      end else begin
        pwr_cnt <= pwr_cnt + `DRKC_ONE;
      end
    end
  end

  // key source selection
  // continuous mode ignores every keying source
  always @* begin
    if (!TRANSMIT_KEY_MODE_SELECT_I) begin
      next_key = pwr_done;
    end else begin
      next_key = key_held | key_src;
    end
  end

  // ========================================================
  // terminal port status toward the customer unit
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      TERM_CTS_O <= 1'b0;
      TERM_RXD_O <= 1'b1; // idle at mark
      TERM_DCD_O <= 1'b0;
    end else begin
      // cts only while rts stands, so a drop clears it at once
      TERM_CTS_O <= cts_del & TERM_RTS_I;
      TERM_RXD_O <= RX_DATA_I;
      TERM_DCD_O <= RX_CARRIER_I;
    end
  end

  // ========================================================
  // feed toward the plug-in synchronizer
  // the copy always runs; only the return path is switched
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SYNC_DATA_O <= 1'b1; // idle at mark
    end else begin
      SYNC_DATA_O <= RX_DATA_I;
    end
  end

  // ========================================================
  // transmit data source: one source only, never a merge
  always @* begin
    if (TERM_RTS_I) begin
      next_tx_data = TERM_TXD_I;
    end else if (SYNCHRONIZER_ENABLE_I) begin
      next_tx_data = SYNC_DATA_I;
    end else begin
      next_tx_data = RX_DATA_I;
    end
  end

  // registered transmit data, mark during reset
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      TX_DATA_O <= 1'b1;
    end else begin
      TX_DATA_O <= next_tx_data;
    end
  end

  // ========================================================
  // key request value, held low while the pin is released
  // so a key-on-data radio never sees a stray key
  always @* begin
    next_key_req = next_key & TRANSMITTER_KEY_INPUT_ENABLE_I;
  end

  // registered key request and its output enable
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      TRANSMITTER_KEY_REQUEST_O <= 1'b0;
      TRANSMITTER_KEY_REQUEST_OE_O <= 1'b0;
    end else begin
      TRANSMITTER_KEY_REQUEST_O <= next_key_req;
      TRANSMITTER_KEY_REQUEST_OE_O <= TRANSMITTER_KEY_INPUT_ENABLE_I;
    end
  end

  // ========================================================
  // orderwire analog mode and radio sleep
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      TX_ANALOG_MODE_O <= 1'b0;
      RADIOS_SLEEP_O <= 1'b0;
    end else begin
      // analog follows voice, no operator step needed
      TX_ANALOG_MODE_O <= VOICE_ACTIVE_I;
      // sleep input idles high, low puts both radios down
      RADIOS_SLEEP_O <= ~SLEEP_N_I;
    end
  end
endmodule

/* tb/drkc_props.sv */
`timescale 1ns/1ps
// ==========
// port checker
module drkc_props (
  input wire MCLK_I, RST_I, TERM_RTS_I, TERM_TXD_I, TERM_CTS_O,
  input wire RX_DATA_I, RX_SQUELCH_OPEN_I, TERM_RXD_O, SLEEP_N_I,
  input wire RADIOS_SLEEP_O, VOICE_ACTIVE_I, TX_ANALOG_MODE_O,
  input wire TX_DATA_O, TRANSMITTER_KEY_REQUEST_O, SYNCHRONIZER_ENABLE_I,
  input wire TRANSMITTER_KEY_REQUEST_OE_O, TRANSMIT_KEY_MODE_SELECT_I,
  input wire TRANSMITTER_KEY_INPUT_ENABLE_I
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  AST_RXD: assert property (!$past(RST_I) |->
    TERM_RXD_O == $past(RX_DATA_I)) else $error("rxd");
  AST_SLP: assert property (!$past(RST_I) |->
    RADIOS_SLEEP_O == !$past(SLEEP_N_I)) else $error("sleep");
  AST_ANA: assert property (!$past(RST_I) |->
    TX_ANALOG_MODE_O == $past(VOICE_ACTIVE_I)) else $error("analog");
  AST_TXT: assert property (!$past(RST_I) && $past(TERM_RTS_I) |->
    TX_DATA_O == $past(TERM_TXD_I)) else $error("tx term");
  AST_REP: assert property (!$past(RST_I) && !$past(TERM_RTS_I) &&
    !$past(SYNCHRONIZER_ENABLE_I) |-> TX_DATA_O == $past(RX_DATA_I))
    else $error("tx rep");
  AST_CTSF: assert property ($fell(TERM_RTS_I) |=> !TERM_CTS_O)
    else $error("cts");
  AST_KEY: assert property (TRANSMIT_KEY_MODE_SELECT_I &&
    TRANSMITTER_KEY_INPUT_ENABLE_I && RX_SQUELCH_OPEN_I
    |-> ##[1:3] TRANSMITTER_KEY_REQUEST_O) else $error("key");
  AST_OE: assert property ((!TRANSMITTER_KEY_INPUT_ENABLE_I)[*2]
    |-> !TRANSMITTER_KEY_REQUEST_OE_O) else $error("oe");
  cover property ($rose(TERM_CTS_O));
  cover property ($fell(TRANSMITTER_KEY_REQUEST_O));
  cover property ($rose(TX_ANALOG_MODE_O));
endmodule

/* tb/drkc_radio_model.sv */
`timescale 1ns/1ps
// ==========
// receiver radio: bursts of data, idle at mark
module drkc_radio_model (
  input wire clk_i,
  input wire on_i,
  output reg data_o,
  output wire squelch_o
);
  reg [1:0] ph = 2'h0;
  initial data_o = 1'b1;
  assign squelch_o = on_i;
  // data toggles only during a burst
  always @(posedge clk_i) begin
    ph <= ph + 2'h1;
    data_o <= on_i ? ph[1] : 1'b1;
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
// ==========
// bench
module tb;
  reg clk = 0, rst = 1, cds = 1, md = 1, hs = 1, en = 1, rts = 0;
  reg txd = 0, sln = 1, voc = 0, on = 0, sen = 0, sdi = 0;
  wire rxd, sq, sdo, cts, trx, txo, key, oe, ana, slp, dcd;
  integer error_cnt = 0, n_tests = 0, cyc = 0, n;
  always #2.5 clk = ~clk;
  drkc_radio_model rad (.clk_i(clk), .on_i(on), .data_o(rxd),
    .squelch_o(sq));
  drkc_top #(20, 40, 4, 40, 10) dut (.MCLK_I(clk), .RST_I(rst),
    .CTS_DELAY_SELECT_I(cds), .TRANSMIT_KEY_MODE_SELECT_I(md),
    .KEY_HOLD_SELECT_I(hs), .TRANSMITTER_KEY_INPUT_ENABLE_I(en),
    .SYNCHRONIZER_ENABLE_I(sen), .TERM_RTS_I(rts), .TERM_TXD_I(txd),
    .TERM_CTS_O(cts), .TERM_RXD_O(trx), .TERM_DCD_O(dcd), .SLEEP_N_I(sln),
    .RX_DATA_I(rxd), .RX_CARRIER_I(sq), .RX_SQUELCH_OPEN_I(sq),
    .SYNC_DATA_I(sdi), .SYNC_DATA_O(sdo), .VOICE_ACTIVE_I(voc),
    .TX_DATA_O(txo), .TRANSMITTER_KEY_REQUEST_O(key),
    .TRANSMITTER_KEY_REQUEST_OE_O(oe), .TX_ANALOG_MODE_O(ana),
    .RADIOS_SLEEP_O(slp));
  task tick(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input c, input [63:0] m);
    begin
      n_tests = n_tests + 1;
      if (c !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t %0s", $time, m);
      end
    end
  endtask
  // terminal raises rts, waits for cts, then drops it
  task t_cts(input s, input integer l);
    begin
      cds = s; rts = 1; n = 0;
      while (cts !== 1'b1 && n < 99) begin
        tick(1); n = n + 1;
      end
      chk(n >= l - 2 && n <= l + 5, "cts");
      chk(txo === 1'b0, "txterm");
      rts = 0; tick(2);
      chk(cts === 1'b0 && txo === 1'b1, "rep");
    end
  endtask
  // squelch burst, then measure hold
  task t_hold(input s, input integer l);
    begin
      hs = s; on = 1; tick(4);
      chk(key === 1'b1, "sqkey");
      on = 0; n = 0;
      while (key === 1'b1 && n < 99) begin
        tick(1); n = n + 1;
      end
      chk(n >= l - 2 && n <= l + 4, "hold");
    end
  endtask
  // burst with synchronizer path on, then off
  task t_sync;
    reg r;
    begin
      sen = 1; sdi = 0; on = 1; tick(2);
      r = rxd; tick(1);
      chk(sdo === r && trx === r, "rxcopy");
      chk(dcd === 1'b1, "dcd");
      chk(txo === 1'b0, "sync0");
      sdi = 1; tick(2); chk(txo === 1'b1, "sync1");
      sdi = 0; tick(2);
      sen = 0; on = 0; tick(2);
      chk(txo === 1'b1 && dcd === 1'b0, "nosync");
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  initial begin
    tick(4); rst = 0; tick(2);
    t_cts(1, 20); t_cts(0, 40);
    t_hold(1, 4); t_hold(0, 40);
    t_sync;
    en = 0; tick(3); chk(oe === 1'b0, "oe");
    en = 1; voc = 1; tick(3); chk(ana & key, "voice");
    voc = 0; sln = 0; tick(2); chk(slp === 1'b1, "sleep");
    md = 0; rst = 1; tick(2); rst = 0; tick(2);
    chk(key === 1'b0, "pwrwait");
    tick(28);
    chk(key === 1'b1, "cont");
    wrap_up;
  end
endmodule
bind drkc_top drkc_props u_props (.*);
